/* design/gauge_defines.svh */
// Purpose: offsets, field positions, reset values and counts of the gauge register map
// Assumes: 7-bit register index, 8-bit registers
// Notes:   definitions only
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PRIMARY_FLAGS   7'h01
`define ADDR_TEMP_LEVEL      7'h02
`define ADDR_AVAIL_HIGH      7'h03
`define ADDR_PACK_TAG        7'h04
`define ADDR_FULL_CAP        7'h05
`define ADDR_SECONDARY_FLAGS 7'h06
`define ADDR_PULLDOWN        7'h07
`define ADDR_PULLUP          7'h08
`define ADDR_CHARGE_COUNT    7'h09
`define ADDR_BATT_VOLTAGE    7'h0b
`define ADDR_EMPTY_THRESH    7'h0c
`define ADDR_TEMP_RATE_CAP   7'h0d
`define ADDR_RATE_CAP        7'h0e
`define ADDR_ENERGY_HIGH     7'h0f
`define ADDR_ENERGY_LOW      7'h10
`define ADDR_REL_CAPACITY    7'h11
`define ADDR_CURRENT_HIGH    7'h12
`define ADDR_CURRENT_LOW     7'h13
`define ADDR_AVAIL_LOW       7'h17
`define ADDR_DISCH_TALLY     7'h18
`define ADDR_PIN_DATA        7'h1e
`define ADDR_OFFSET_EVENT    7'h38

// ----------------------------------------------------------------
// command and flag fields
// ----------------------------------------------------------------
`define CMD_WRITE_BIT        7
`define FLAG_CHARGING        7
`define FLAG_PACK_RESET      6
`define FLAG_ZERO            5
`define FLAG_STALE_REF       4
`define FLAG_QUAL_DISCH      3
`define FLAG_ONE             2
`define FLAG_FIRST_EMPTY     1
`define FLAG_FINAL_EMPTY     0

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_BYTE             8'h00
`define RST_AVAIL            16'h0000
`define CHARGE_COUNT_STALE   8'h40
`define CHARGE_COUNT_MAX     8'hff
`define QUAL_NUM             24'd94
`define QUAL_DEN             24'd100
`define SELF_DISCH_SHIFT     4
`define QUAL_CLEAR_UPDATES   2'd2
`endif

/* design/gauge_pkg.sv */
// Purpose: types shared by the gauge register block
// Assumes: nothing
// Notes:   constants live in gauge_defines.svh
package gauge_pkg;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b001,
    ST_WDATA = 3'b010,
    ST_READ  = 3'b100
  } cmd_state_t;

  // measurement core to register block
  typedef struct packed {
    logic        senseAboveQual;
    logic        dischargeActive;
    logic        chargeValid;
    logic        dischargeStart;
    logic        nacUpdate;
    logic        selfDischarge;
    logic [15:0] nacNext;
    logic        lmdUpdate;
    logic [7:0]  lmdNext;
    logic        firstEmpty;
    logic        finalEmpty;
    logic        tempBelowZero;
    logic [7:0]  tempLevel;
    logic [7:0]  secondaryFlags;
    logic [7:0]  pulldownState;
    logic [7:0]  pullupState;
    logic [7:0]  batteryVoltage;
    logic [15:0] scaledEnergy;
    logic [7:0]  relativeCapacity;
    logic [15:0] currentScale;
  } gauge_in_t;

  // register block to measurement core
  typedef struct packed {
    logic [15:0] availCharge;
    logic [7:0]  fullCapacity;
    logic [7:0]  chargeCount;
    logic [7:0]  packTag;
    logic [7:0]  emptyThreshold;
    logic [7:0]  tempRateCap;
    logic [7:0]  rateCap;
    logic [7:0]  dischTally;
    logic [7:0]  offsetEvent;
    logic [7:0]  primaryFlags;
  } gauge_out_t;

endpackage

/* design/serial_byte_port.sv */
// Purpose: byte assembly and serialisation for the single-wire link
// Assumes: a front end delivers decoded bits and a break indication
// Notes:   lsb first in both directions
module serial_byte_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // receive side
  input  wire logic       lineBreak,
  input  wire logic       rxBitValid,
  input  wire logic       rxBit,
  output logic            rxByteValid,
  output logic [7:0]      rxByte,
  // transmit side
  input  wire logic       txLoad,
  input  wire logic [7:0] txByte,
  input  wire logic       txBitReq,
  output logic            txBit,
  output logic            txBusy
);

  logic [7:0] rxShift_q;
  logic [2:0] rxCount_q;
  logic [7:0] txShift_q;
  logic [3:0] txLeft_q;

  assign txBusy = (txLeft_q != 4'h0);

  // ----------------------------------------------------------------
  // receive: bits shift in from the top, first bit ends at bit 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || (ce && lineBreak)) begin
      rxShift_q   <= 8'h00;
      rxCount_q   <= 3'h0;
      rxByteValid <= 1'b0;
      rxByte      <= 8'h00;
    end else if (ce) begin
      rxByteValid <= 1'b0;
      if (rxBitValid) begin
        rxShift_q <= {rxBit, rxShift_q[7:1]};
        rxCount_q <= rxCount_q + 3'h1;
        if (rxCount_q == 3'h7) begin
          rxByteValid <= 1'b1;
          rxByte      <= {rxBit, rxShift_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit: bit 0 leaves first
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || (ce && lineBreak)) begin
      txShift_q <= 8'h00;
      txLeft_q  <= 4'h0;
      txBit     <= 1'b1;
    end else if (ce) begin
      if (txLoad) begin
        txShift_q <= txByte;
        txLeft_q  <= 4'h8;
      end else if (txBitReq && txBusy) begin
        txBit     <= txShift_q[0];
        txShift_q <= {1'b0, txShift_q[7:1]};
        txLeft_q  <= txLeft_q - 4'h1;
      end
    end
  end

endmodule

/* design/gauge_command_and_status_regs.sv */
// Purpose: command decoder, register map and primary status flags of the gauge
// Assumes: bit timing and measurement are done outside; inputs synchronous to clk
// Notes:   20 MHz clock; ce low freezes all state
`include "gauge_defines.svh"

// Behaviour
// - a command is taken only after all eight command bits arrived
// - command msb 0 returns the addressed register's eight bits
// - command msb 1 stores the following data byte into the addressed register
// - command bits 6..0 form the register index, bit 0 least significant
// - flags at 01h: bit 5 reads 0, bit 2 reads 1, bits 1/0 empty warnings
// - charging flag set while offset exceeds threshold, cleared by discharge or not above
// - pack reset flag set on any reset, power-up or serial reset request
// - pack reset flag cleared when charge reaches full capacity or charges after warning
// - stale flag set on reset or 64th valid charge, cleared on capacity update
// - qualified discharge set when discharge starts at 0.94 of full capacity or more
// - qualified discharge cleared after self-discharge loss above 6.25 percent
// - qualified discharge cleared after charge above threshold over two updates
// - qualified discharge cleared when first warning sets below zero degrees
// - available charge high byte at 03h, low byte 17h, both writable
// - bytes travel least significant bit first
// - valid charge count saturates at 255, cleared on capacity update
// - a break reinitialises the serial side and awaits a new command
module gauge_command_and_status_regs #(
  parameter logic [7:0] FULL_CAP_RESET = 8'h00
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  packResetReq,
  // serial front end
  input  wire logic                  lineBreak,
  input  wire logic                  rxBitValid,
  input  wire logic                  rxBit,
  input  wire logic                  txBitReq,
  output logic                       txBit,
  output logic                       txBusy,
  // measurement core
  input  wire gauge_pkg::gauge_in_t  core,
  output gauge_pkg::gauge_out_t      regs
);
  import gauge_pkg::*;

  cmd_state_t  state_q;
  cmd_state_t  state_d;
  logic [6:0]  addr_q;
  logic        rxByteValid;
  logic [7:0]  rxByte;
  logic [15:0] avail_q;
  logic [7:0]  fullCap_q;
  logic [7:0]  chargeCount_q;
  logic [7:0]  packTag_q;
  logic [7:0]  emptyThresh_q;
  logic [7:0]  tempRateCap_q;
  logic [7:0]  rateCap_q;
  logic [7:0]  dischTally_q;
  logic [7:0]  offsetEvent_q;
  logic        charging_q;
  logic        packReset_q;
  logic        staleRef_q;
  logic        qualDisch_q;
  logic [15:0] qualBase_q;
  logic [15:0] selfLoss_q;
  logic [1:0]  chargeRun_q;
  logic        firstEmptyPrev_q;

  // ----------------------------------------------------------------
  // byte level serial port
  // ----------------------------------------------------------------
  wire        cmdTaken  = ce && rxByteValid && (state_q == ST_CMD);
  wire        cmdWrite  = rxByte[`CMD_WRITE_BIT];
  wire [6:0]  cmdAddr   = rxByte[6:0];
  wire        readStart = cmdTaken && !cmdWrite;
  wire        wrStrobe  = ce && rxByteValid && (state_q == ST_WDATA);
  wire [7:0]  readData;

  serial_byte_port u_port (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .lineBreak   (lineBreak),
    .rxBitValid  (rxBitValid),
    .rxBit       (rxBit),
    .rxByteValid (rxByteValid),
    .rxByte      (rxByte),
    .txLoad      (readStart),
    .txByte      (readData),
    .txBitReq    (txBitReq),
    .txBit       (txBit),
    .txBusy      (txBusy)
  );

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CMD: begin
        if (rxByteValid) begin
          state_d = rxByte[`CMD_WRITE_BIT] ? ST_WDATA : ST_READ;
        end
      end
      ST_WDATA: begin
        if (rxByteValid) begin
          state_d = ST_CMD;
        end
      end
      ST_READ: begin
        if (!txBusy) begin
          state_d = ST_CMD;
        end
      end
      default: state_d = ST_CMD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_CMD;
      addr_q  <= 7'h00;
    end else if (ce) begin
      state_q <= lineBreak ? ST_CMD : state_d;
      if (cmdTaken) begin
        addr_q <= cmdAddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode; read-only and reserved addresses have no strobe
  // ----------------------------------------------------------------
  wire wrAvailHigh = wrStrobe && (addr_q == `ADDR_AVAIL_HIGH);
  wire wrAvailLow  = wrStrobe && (addr_q == `ADDR_AVAIL_LOW);
  wire wrPackTag   = wrStrobe && (addr_q == `ADDR_PACK_TAG);
  wire wrFullCap   = wrStrobe && (addr_q == `ADDR_FULL_CAP);
  wire wrCount     = wrStrobe && (addr_q == `ADDR_CHARGE_COUNT);
  wire wrThresh    = wrStrobe && (addr_q == `ADDR_EMPTY_THRESH);
  wire wrTempRate  = wrStrobe && (addr_q == `ADDR_TEMP_RATE_CAP);
  wire wrRate      = wrStrobe && (addr_q == `ADDR_RATE_CAP);
  wire wrTally     = wrStrobe && (addr_q == `ADDR_DISCH_TALLY);
  wire wrOffset    = wrStrobe && (addr_q == `ADDR_OFFSET_EVENT);

  // ----------------------------------------------------------------
  // writable storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      avail_q       <= `RST_AVAIL;
      fullCap_q     <= FULL_CAP_RESET;
      packTag_q     <= `RST_BYTE;
      emptyThresh_q <= `RST_BYTE;
      tempRateCap_q <= `RST_BYTE;
      rateCap_q     <= `RST_BYTE;
      dischTally_q  <= `RST_BYTE;
      offsetEvent_q <= `RST_BYTE;
    end else if (ce) begin
      if (wrAvailHigh) begin
        avail_q[15:8] <= rxByte;
      end else if (wrAvailLow) begin
        avail_q[7:0] <= rxByte;
      end else if (core.nacUpdate) begin
        avail_q <= core.nacNext;
      end
      if (wrFullCap) begin
        fullCap_q <= rxByte;
      end else if (core.lmdUpdate) begin
        fullCap_q <= core.lmdNext;
      end
      if (wrPackTag) begin
        packTag_q <= rxByte;
      end
      if (wrThresh) begin
        emptyThresh_q <= rxByte;
      end
      if (wrTempRate) begin
        tempRateCap_q <= rxByte;
      end
      if (wrRate) begin
        rateCap_q <= rxByte;
      end
      if (wrTally) begin
        dischTally_q <= rxByte;
      end
      if (wrOffset) begin
        offsetEvent_q <= rxByte;
      end
    end
  end

  // ----------------------------------------------------------------
  // valid charge count and stale reference flag
  // ----------------------------------------------------------------
  wire countSat = (chargeCount_q == `CHARGE_COUNT_MAX);
  wire staleHit = core.chargeValid && !countSat && !core.lmdUpdate && !wrCount
                  && (chargeCount_q + 8'h01 == `CHARGE_COUNT_STALE);

  always_ff @(posedge clk) begin
    if (rst) begin
      chargeCount_q <= `RST_BYTE;
      staleRef_q    <= 1'b1;
    end else if (ce) begin
      if (core.lmdUpdate) begin
        chargeCount_q <= `RST_BYTE;
      end else if (wrCount) begin
        chargeCount_q <= rxByte;
      end else if (core.chargeValid && !countSat) begin
        chargeCount_q <= chargeCount_q + 8'h01;
      end
      if (staleHit) begin
        staleRef_q <= 1'b1;
      end else if (core.lmdUpdate) begin
        staleRef_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // charging and pack reset flags
  // ----------------------------------------------------------------
  wire reachFull = core.chargeValid && core.nacUpdate && (core.nacNext[15:8] == fullCap_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      charging_q  <= 1'b0;
      packReset_q <= 1'b1;
    end else if (ce) begin
      charging_q <= core.senseAboveQual && !core.dischargeActive;
      if (packResetReq) begin
        packReset_q <= 1'b1;
      end else if (reachFull || (core.chargeValid && core.firstEmpty)) begin
        packReset_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // qualified discharge flag
  // ----------------------------------------------------------------
  wire [23:0] availScaled = 24'(avail_q) * `QUAL_DEN;
  wire [23:0] fullScaled  = 24'({fullCap_q, 8'h00}) * `QUAL_NUM;
  wire        qualSet     = core.dischargeStart && (availScaled >= fullScaled);
  wire [15:0] selfStep    = (core.nacUpdate && core.selfDischarge && (avail_q > core.nacNext))
                            ? (avail_q - core.nacNext) : 16'h0000;
  wire [15:0] selfLossNew = selfLoss_q + selfStep;
  wire        selfClear   = selfLossNew > (qualBase_q >> `SELF_DISCH_SHIFT);
  wire        chargeUpd   = core.nacUpdate && core.chargeValid && core.senseAboveQual;
  wire        chargeClear = chargeUpd && (3'(chargeRun_q) + 3'd1 >= 3'(`QUAL_CLEAR_UPDATES));
  wire        coldClear   = core.firstEmpty && !firstEmptyPrev_q && core.tempBelowZero;
  wire        qualClear   = core.lmdUpdate || selfClear || chargeClear || coldClear;

  always_ff @(posedge clk) begin
    if (rst) begin
      qualDisch_q      <= 1'b0;
      qualBase_q       <= 16'h0000;
      selfLoss_q       <= 16'h0000;
      chargeRun_q      <= 2'd0;
      firstEmptyPrev_q <= 1'b0;
    end else if (ce) begin
      firstEmptyPrev_q <= core.firstEmpty;
      if (core.nacUpdate) begin
        chargeRun_q <= chargeUpd ? ((chargeRun_q == 2'd3) ? chargeRun_q : chargeRun_q + 2'd1) : 2'd0;
      end
      if (qualSet && !qualDisch_q) begin
        qualDisch_q <= 1'b1;
        qualBase_q  <= avail_q;
        selfLoss_q  <= 16'h0000;
      end else if (qualDisch_q && qualClear) begin
        qualDisch_q <= 1'b0;
      end else if (qualDisch_q) begin
        selfLoss_q <= selfLossNew;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] primaryFlags = {charging_q, packReset_q, 1'b0, staleRef_q,
                             qualDisch_q, 1'b1, core.firstEmpty, core.finalEmpty};

  assign readData =
    (cmdAddr == `ADDR_PRIMARY_FLAGS)   ? primaryFlags :
    (cmdAddr == `ADDR_TEMP_LEVEL)      ? core.tempLevel :
    (cmdAddr == `ADDR_AVAIL_HIGH)      ? avail_q[15:8] :
    (cmdAddr == `ADDR_PACK_TAG)        ? packTag_q :
    (cmdAddr == `ADDR_FULL_CAP)        ? fullCap_q :
    (cmdAddr == `ADDR_SECONDARY_FLAGS) ? core.secondaryFlags :
    (cmdAddr == `ADDR_PULLDOWN)        ? core.pulldownState :
    (cmdAddr == `ADDR_PULLUP)          ? core.pullupState :
    (cmdAddr == `ADDR_CHARGE_COUNT)    ? chargeCount_q :
    (cmdAddr == `ADDR_BATT_VOLTAGE)    ? core.batteryVoltage :
    (cmdAddr == `ADDR_EMPTY_THRESH)    ? emptyThresh_q :
    (cmdAddr == `ADDR_TEMP_RATE_CAP)   ? tempRateCap_q :
    (cmdAddr == `ADDR_RATE_CAP)        ? rateCap_q :
    (cmdAddr == `ADDR_ENERGY_HIGH)     ? core.scaledEnergy[15:8] :
    (cmdAddr == `ADDR_ENERGY_LOW)      ? core.scaledEnergy[7:0] :
    (cmdAddr == `ADDR_REL_CAPACITY)    ? core.relativeCapacity :
    (cmdAddr == `ADDR_CURRENT_HIGH)    ? core.currentScale[15:8] :
    (cmdAddr == `ADDR_CURRENT_LOW)     ? core.currentScale[7:0] :
    (cmdAddr == `ADDR_AVAIL_LOW)       ? avail_q[7:0] :
    (cmdAddr == `ADDR_DISCH_TALLY)     ? dischTally_q :
    (cmdAddr == `ADDR_OFFSET_EVENT)    ? offsetEvent_q :
                                         `RST_BYTE;

  assign regs.availCharge    = avail_q;
  assign regs.fullCapacity   = fullCap_q;
  assign regs.chargeCount    = chargeCount_q;
  assign regs.packTag        = packTag_q;
  assign regs.emptyThreshold = emptyThresh_q;
  assign regs.tempRateCap    = tempRateCap_q;
  assign regs.rateCap        = rateCap_q;
  assign regs.dischTally     = dischTally_q;
  assign regs.offsetEvent    = offsetEvent_q;
  assign regs.primaryFlags   = primaryFlags;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_WRITE_CMD_AWAITS_DATA: assert property (@(posedge clk) disable iff (rst)
    cmdTaken && cmdWrite && !lineBreak |=> state_q == ST_WDATA && addr_q == $past(cmdAddr))
    else $error("write command did not await data");

  AST_READ_CMD_STARTS_TX: assert property (@(posedge clk) disable iff (rst)
    readStart && !lineBreak |=> txBusy && state_q == ST_READ)
    else $error("read command did not start transmit");

  AST_FIXED_FLAG_BITS: assert property (@(posedge clk) disable iff (rst)
    primaryFlags[`FLAG_ZERO] == 1'b0 && primaryFlags[`FLAG_ONE] == 1'b1)
    else $error("fixed flag bits wrong");

  AST_CHARGING_FOLLOWS_SENSE: assert property (@(posedge clk) disable iff (rst)
    ce |=> charging_q == ($past(core.senseAboveQual) && !$past(core.dischargeActive)))
    else $error("charging flag wrong");

  AST_PACK_RESET_REQ: assert property (@(posedge clk) disable iff (rst)
    ce && packResetReq |=> packReset_q)
    else $error("pack reset flag not set");

  AST_CAP_UPDATE_CLEARS: assert property (@(posedge clk) disable iff (rst)
    ce && core.lmdUpdate |=> !staleRef_q && chargeCount_q == 8'h00)
    else $error("capacity update did not clear count");

  AST_COUNT_SATURATES: assert property (@(posedge clk) disable iff (rst)
    ce && countSat && !core.lmdUpdate && !wrCount |=> chargeCount_q == 8'hff)
    else $error("charge count wrapped");

  AST_COLD_WARNING_CLEARS: assert property (@(posedge clk) disable iff (rst)
    ce && qualDisch_q && coldClear |=> !qualDisch_q)
    else $error("cold warning did not clear qualified discharge");

  AST_READONLY_KEPT: assert property (@(posedge clk) disable iff (rst)
    ce && wrStrobe && addr_q == `ADDR_ENERGY_HIGH && !core.nacUpdate && !core.lmdUpdate
    |=> $stable(avail_q) && $stable(fullCap_q))
    else $error("read-only write changed storage");

  COV_READ: cover property (@(posedge clk) disable iff (rst) readStart ##[1:40] state_q == ST_CMD);
  COV_WRITE: cover property (@(posedge clk) disable iff (rst) wrAvailHigh);
  COV_QUAL: cover property (@(posedge clk) disable iff (rst) qualSet ##[1:200] !qualDisch_q);

endmodule

/* testbench/host_model.sv */
// Purpose: host side of the single-wire link, bit level
// Assumes: front end bit pulses as in the hand-over contract
// Notes:   tasks are called by the bench
module host_model (
  // clock
  input  wire logic clk,
  // device answer
  input  wire logic txBit,
  input  wire logic txBusy,
  // host requests
  output logic      rxBitValid,
  output logic      rxBit,
  output logic      txBitReq,
  output logic      lineBreak
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // bit tasks
  // ----------------------------------------------------------------
  initial begin
    rxBitValid = 1'b0;
    rxBit      = 1'b0;
    txBitReq   = 1'b0;
    lineBreak  = 1'b0;
  end
  // lsb first; idle line shows the inverse of the last bit
  task automatic sendBits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxBitValid <= 1'b1;
      rxBit      <= b[i];
    end
    @(posedge clk);
    rxBitValid <= 1'b0;
    rxBit      <= ~b[n-1];
  endtask
  task automatic readByte(output logic [7:0] b, output logic ok);
    int w;
    w = 0;
    while (txBusy !== 1'b1 && w < 20) begin
      @(negedge clk);
      w++;
    end
    ok = (txBusy === 1'b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      txBitReq <= 1'b1;
      @(posedge clk);
      txBitReq <= 1'b0;
      @(negedge clk);
      b[i] = txBit;
    end
  endtask
  // host sends a break after an error
  task automatic sendBreak();
    @(posedge clk);
    lineBreak <= 1'b1;
    @(posedge clk);
    lineBreak <= 1'b0;
  endtask
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the gauge register block
// Assumes: host_model drives the bit-level link
// Notes:   table loop first, then reset and flag cases
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gauge_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       clk, rst, ce, packResetReq, lineBreak, rxBitValid, rxBit, txBitReq, txBit, txBusy;
  gauge_in_t  core;
  gauge_out_t regs;
  int         miscompares, check_count;
  row_t rows [14] = '{'{7'h01, 8'hff, 8'h54}, '{7'h03, 8'h10, 8'h10}, '{7'h17, 8'hc3, 8'hc3},
    '{7'h04, 8'h5a, 8'h5a}, '{7'h05, 8'h10, 8'h10}, '{7'h09, 8'h22, 8'h22}, '{7'h0c, 8'h81, 8'h81},
    '{7'h0d, 8'h7e, 8'h7e}, '{7'h0e, 8'h3c, 8'h3c}, '{7'h18, 8'he7, 8'he7}, '{7'h38, 8'h09, 8'h09},
    '{7'h0f, 8'h00, 8'ha5}, '{7'h10, 8'hff, 8'h5a}, '{7'h7f, 8'h33, 8'h00}};
  gauge_command_and_status_regs i_dut (.clk(clk), .rst(rst), .ce(ce), .packResetReq(packResetReq),
    .lineBreak(lineBreak), .rxBitValid(rxBitValid), .rxBit(rxBit), .txBitReq(txBitReq),
    .txBit(txBit), .txBusy(txBusy), .core(core), .regs(regs));
  host_model i_host (.clk(clk), .txBit(txBit), .txBusy(txBusy), .rxBitValid(rxBitValid),
    .rxBit(rxBit), .txBitReq(txBitReq), .lineBreak(lineBreak));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.sendBits({1'b1, a}, 8);
    i_host.sendBits(d, 8);
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string what);
    logic [7:0] v;
    logic       ok;
    i_host.sendBits({1'b0, a}, 8);
    i_host.readByte(v, ok);
    check({7'h00, ok}, 8'h01, "read answer");
    check(v, e, what);
    repeat (2) @(posedge clk);
  endtask
  task automatic nacStep(input logic chg, input logic slf, input logic [15:0] nxt);
    @(posedge clk) begin
      core.nacUpdate     <= 1'b1;
      core.chargeValid   <= chg;
      core.selfDischarge <= slf;
      core.nacNext       <= nxt;
    end
    @(posedge clk) begin
      core.nacUpdate     <= 1'b0;
      core.chargeValid   <= 1'b0;
      core.selfDischarge <= 1'b0;
    end
  endtask
  task automatic startDisch();
    @(posedge clk) core.dischargeStart <= 1'b1;
    @(posedge clk) core.dischargeStart <= 1'b0;
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    packResetReq = 1'b0;
    core = '0;
    core.scaledEnergy = 16'ha55a;
    core.lmdNext = 8'h10;
    miscompares = 0;
    check_count = 0;
    doReset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "table read");
    end
    check(regs.availCharge[7:0], 8'hc3, "charge low out");
    check(regs.packTag, 8'h5a, "tag out");
    doReset();
    rd(7'h01, 8'h54, "flags after reset");
    rd(7'h03, 8'h00, "charge after reset");
    @(posedge clk) core.lmdUpdate <= 1'b1;
    @(posedge clk) core.lmdUpdate <= 1'b0;
    rd(7'h01, 8'h44, "stale cleared");
    rd(7'h05, 8'h10, "capacity updated");
    wr(7'h03, 8'h10);
    wr(7'h09, 8'h3f);
    nacStep(1'b1, 1'b0, 16'h1000);
    rd(7'h01, 8'h14, "pack reset clear, stale at 64");
    rd(7'h09, 8'h40, "charge count");
    wr(7'h09, 8'hff);
    @(posedge clk) core.chargeValid <= 1'b1;
    @(posedge clk) core.chargeValid <= 1'b0;
    rd(7'h09, 8'hff, "count saturates");
    @(posedge clk) core.senseAboveQual <= 1'b1;
    rd(7'h01, 8'h94, "charging set");
    @(posedge clk) core.dischargeActive <= 1'b1;
    rd(7'h01, 8'h14, "charging cleared");
    @(posedge clk) core.senseAboveQual <= 1'b0;
    @(posedge clk) packResetReq <= 1'b1;
    @(posedge clk) packResetReq <= 1'b0;
    rd(7'h01, 8'h54, "serial reset sets flag");
    i_host.sendBits(8'h84, 3);
    i_host.sendBreak();
    wr(7'h04, 8'h99);
    rd(7'h04, 8'h99, "after break");
    @(posedge clk) begin
      core.senseAboveQual  <= 1'b1;
      core.dischargeActive <= 1'b0;
    end
    startDisch();
    rd(7'h01, 8'hdc, "qualified discharge set");
    nacStep(1'b1, 1'b0, 16'h1000);
    rd(7'h01, 8'h9c, "one charge update keeps flag");
    nacStep(1'b1, 1'b0, 16'h1000);
    rd(7'h01, 8'h94, "two charge updates clear flag");
    startDisch();
    rd(7'h01, 8'h9c, "qualified discharge set again");
    @(posedge clk) begin
      core.tempBelowZero <= 1'b1;
      core.firstEmpty    <= 1'b1;
    end
    rd(7'h01, 8'h96, "cold warning clears flag");
    @(posedge clk) core.firstEmpty <= 1'b0;
    startDisch();
    nacStep(1'b0, 1'b1, 16'h0f00);
    rd(7'h01, 8'h9c, "self-discharge at limit keeps flag");
    nacStep(1'b0, 1'b1, 16'h0eff);
    rd(7'h01, 8'h94, "self-discharge above limit clears");
    ce <= 1'b0;
    i_host.sendBits(8'h84, 8);
    @(posedge clk) ce <= 1'b1;
    rd(7'h04, 8'h99, "bits ignored while frozen");
    complete_run();
  end
endmodule
